// ### hdl/dccf_device.sv
// Notes on behaviour
// - gain 14-bit samples, round, alternate even/odd words
// - mode low sample/hold, high double sampling
// - reset low loads register defaults asynchronously
// - gain linear from zero to just under four
// - black level is two LSB per code
// - offset loop converges only during black strobe
// - black period outputs clamp level, later base
// - gain outside loop leaves black level unchanged
// - charge input clamp on clamp and sampling strobe
// - partner strobes input clamp during dummy pixels
// - pixel is reference minus data sample
// - partner waits settle time before trusting data
// - register bit switches standby
// - standby freezes datapath, registers stay accessible
// - partner gives three pixel clocks before commands
// - gain is code over 256, default one quarter
// - standby bit one is standby, default normal
// - order bit picks first word, default even
`timescale 1ns/10ps
`include "dccf_map.svh"
module dccf_device import dccf_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // timing generator link
  dccf_link_if.dev link,
  // converter side
  input wire dccf_sample_t sensor_level_even,
  input wire dccf_sample_t sensor_level_odd,
  output logic input_clamp_charge,
  output logic standby_active
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int S_PCLK = 0;
  localparam int S_REF = 1;
  localparam int S_DAT = 2;
  localparam int S_ICL = 3;
  localparam int S_BCL = 4;
  localparam int S_MODE = 5;
  localparam int S_WR = 6;
  localparam int S_RD = 7;

  logic [7:0] sync1_reg, sync2_reg, sync3_reg;
  logic [7:0] pins, rise;

  assign pins = {link.reg_rd, link.reg_wr, link.sample_mode_select, link.black_level_clamp_strobe,
                 link.input_clamp_strobe, link.data_sample_strobe, link.reference_sample_strobe,
                 link.pixel_clock};
  assign rise = sync2_reg & ~sync3_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic order_reg, order_next;
  logic standby_reg, standby_next;
  logic [9:0] gain_reg [2];
  logic [9:0] gain_next [2];
  logic [7:0] clamp_reg [2];
  logic [7:0] clamp_next [2];
  logic [9:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // register latch stands in for the serial shift/latch; addr and data are held by the host
  always_comb begin
    order_next = order_reg;
    standby_next = standby_reg;
    gain_next = gain_reg;
    clamp_next = clamp_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (rise[S_WR]) begin
      case (link.reg_addr)
        `DCCF_ADDR_CONFIG: order_next = link.reg_wdata[`DCCF_CFG_ORDER_BIT];
        `DCCF_ADDR_STANDBY: standby_next = link.reg_wdata[`DCCF_STANDBY_BIT];
        `DCCF_ADDR_GAIN_EVEN: gain_next[0] = link.reg_wdata;
        `DCCF_ADDR_GAIN_ODD: gain_next[1] = link.reg_wdata;
        `DCCF_ADDR_CLAMP_EVEN: clamp_next[0] = link.reg_wdata[7:0];
        `DCCF_ADDR_CLAMP_ODD: clamp_next[1] = link.reg_wdata[7:0];
        default: ;
      endcase
    end
    // reads keep working in standby
    if (rise[S_RD]) begin
      rvalid_next = 1'b1;
      case (link.reg_addr)
        `DCCF_ADDR_CONFIG: rdata_next = 10'(32'(order_reg) << `DCCF_CFG_ORDER_BIT);
        `DCCF_ADDR_STANDBY: rdata_next = {9'h000, standby_reg};
        `DCCF_ADDR_GAIN_EVEN: rdata_next = gain_reg[0];
        `DCCF_ADDR_GAIN_ODD: rdata_next = gain_reg[1];
        `DCCF_ADDR_CLAMP_EVEN: rdata_next = {2'h0, clamp_reg[0]};
        `DCCF_ADDR_CLAMP_ODD: rdata_next = {2'h0, clamp_reg[1]};
        default: rdata_next = 10'h000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      order_reg <= `DCCF_ORDER_RST;
      standby_reg <= `DCCF_STANDBY_RST;
      gain_reg[0] <= `DCCF_GAIN_RST;
      gain_reg[1] <= `DCCF_GAIN_RST;
      clamp_reg[0] <= `DCCF_CLAMP_RST;
      clamp_reg[1] <= `DCCF_CLAMP_RST;
      rdata_reg <= 10'h000;
      rvalid_reg <= 1'b0;
    end else begin
      order_reg <= order_next;
      standby_reg <= standby_next;
      gain_reg <= gain_next;
      clamp_reg <= clamp_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------
  // gain, rounding and black level
  // ----------------------------------------
  // black level added after the gain so a gain change never moves it
  function automatic dccf_word_t gain_word(input logic signed [15:0] lvl, input logic [9:0] g,
                                           input logic [7:0] c);
    logic [13:0] mag;
    logic [23:0] prod;
    logic [16:0] scaled;
    logic [17:0] sum;
    mag = (lvl < 0) ? 14'h0000 : ((lvl > 16'sh3FFF) ? `DCCF_LEVEL_MAX : lvl[13:0]);
    prod = 24'(mag) * 24'(g);
    scaled = 17'((prod + `DCCF_ROUND_ADD) >> `DCCF_SCALE_SHIFT);
    sum = 18'(scaled) + 18'({c, 1'b0});
    gain_word = (sum > 18'(`DCCF_WORD_MAX)) ? `DCCF_WORD_MAX : sum[11:0];
  endfunction : gain_word

  // ----------------------------------------
  // sampling, clamp and black loop
  // ----------------------------------------
  dccf_sample_t sens [2];
  dccf_sample_t ref_smp_reg [2];
  dccf_sample_t ref_smp_next [2];
  dccf_sample_t clamp_ref_reg [2];
  dccf_sample_t clamp_ref_next [2];
  logic signed [15:0] offset_reg [2];
  logic signed [15:0] offset_next [2];
  logic signed [15:0] lvl_c [2];
  dccf_word_t result_reg [2];
  dccf_word_t result_next [2];
  dccf_word_t hold_reg, hold_next, word_reg, word_next;
  logic phase_reg, phase_next, valid_reg, valid_next, odd_reg, odd_next;
  logic charge_reg, charge_next;
  logic cds_mode, sampling;

  assign sens[0] = sensor_level_even;
  assign sens[1] = sensor_level_odd;
  assign cds_mode = sync2_reg[S_MODE];
  assign sampling = cds_mode ? sync2_reg[S_REF] : sync2_reg[S_DAT];

  always_comb begin
    ref_smp_next = ref_smp_reg;
    clamp_ref_next = clamp_ref_reg;
    offset_next = offset_reg;
    result_next = result_reg;
    hold_next = hold_reg;
    word_next = word_reg;
    phase_next = phase_reg;
    odd_next = odd_reg;
    valid_next = 1'b0;
    lvl_c[0] = 16'sh0000;
    lvl_c[1] = 16'sh0000;
    // whole datapath idles in standby
    charge_next = !standby_reg && sync2_reg[S_ICL] && sampling;
    for (int ch = 0; ch < 2; ch++) begin
      if (charge_next) begin
        clamp_ref_next[ch] = sens[ch];
      end
      if (!standby_reg && cds_mode && rise[S_REF]) begin
        ref_smp_next[ch] = sens[ch];
      end
      if (!standby_reg && rise[S_DAT]) begin
        // sample/hold mode measures against the clamped dummy level
        lvl_c[ch] = 16'(signed'({2'b00, cds_mode ? ref_smp_reg[ch] : clamp_ref_reg[ch]}))
                    - 16'(signed'({2'b00, sens[ch]})) - offset_reg[ch];
        if (sync2_reg[S_BCL]) begin
          if (lvl_c[ch] > 0) begin
            offset_next[ch] = offset_reg[ch] + 16'sh0001;
          end else if (lvl_c[ch] < 0) begin
            offset_next[ch] = offset_reg[ch] - 16'sh0001;
          end
          result_next[ch] = {3'h0, clamp_reg[ch], 1'b0};
        end else begin
          result_next[ch] = gain_word(lvl_c[ch], gain_reg[ch], clamp_reg[ch]);
        end
      end
    end
    if (standby_reg) begin
      phase_next = 1'b0;
    end else if (rise[S_PCLK]) begin
      valid_next = 1'b1;
      // pair snapshot at its first word keeps a mid-pair write out of it
      if (!phase_reg) begin
        word_next = order_reg ? result_reg[1] : result_reg[0];
        hold_next = order_reg ? result_reg[0] : result_reg[1];
        odd_next = order_reg;
        phase_next = 1'b1;
      end else begin
        word_next = hold_reg;
        // second flag follows the first, so a mid-pair order write cannot mislabel it
        odd_next = !odd_reg;
        phase_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < 2; ch++) begin
        ref_smp_reg[ch] <= 14'h0000;
        clamp_ref_reg[ch] <= 14'h0000;
        offset_reg[ch] <= 16'sh0000;
        result_reg[ch] <= 12'h000;
      end
      hold_reg <= 12'h000;
      word_reg <= 12'h000;
      phase_reg <= 1'b0;
      odd_reg <= 1'b0;
      valid_reg <= 1'b0;
      charge_reg <= 1'b0;
    end else begin
      ref_smp_reg <= ref_smp_next;
      clamp_ref_reg <= clamp_ref_next;
      offset_reg <= offset_next;
      result_reg <= result_next;
      hold_reg <= hold_next;
      word_reg <= word_next;
      phase_reg <= phase_next;
      odd_reg <= odd_next;
      valid_reg <= valid_next;
      charge_reg <= charge_next;
    end
  end

  assign link.reg_rdata = rdata_reg;
  assign link.reg_rvalid = rvalid_reg;
  assign link.out_word = word_reg;
  assign link.out_word_valid = valid_reg;
  assign link.out_word_odd = odd_reg;
  assign input_clamp_charge = charge_reg;
  assign standby_active = standby_reg;

endmodule : dccf_device

// ### hdl/dccf_host.sv
`timescale 1ns/10ps
`include "dccf_map.svh"
module dccf_host import dccf_pkg::*; #(
  parameter int SETTLE_CYC = `DCCF_SETTLE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link to front end
  dccf_link_if.host link,
  // user control
  input wire logic clock_run,
  input wire logic cds_mode,
  // register commands
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_addr,
  input wire logic [9:0] cmd_wdata,
  output logic cmd_ready,
  output logic [9:0] rsp_data,
  output logic rsp_valid,
  // pixel words
  output dccf_word_t pix_word,
  output logic pix_valid,
  output logic pix_odd,
  output logic data_trusted
);

  // ----------------------------------------
  // pixel clock divider and line sequencer
  // ----------------------------------------
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] npix_reg, npix_next;
  dccf_line_e line_reg, line_next;
  logic pclk_reg, ref_reg, dat_reg, icl_reg, bcl_reg, mode_reg;
  logic pclk_next, ref_next, dat_next, icl_next, bcl_next;
  logic [7:0] line_len;

  always_comb begin
    case (line_reg)
      DCCF_LINE_DUMMY: line_len = 8'(`DCCF_N_DUMMY);
      DCCF_LINE_BLACK: line_len = 8'(`DCCF_N_OB);
      DCCF_LINE_EFF: line_len = 8'(`DCCF_N_EFF);
      DCCF_LINE_GAP: line_len = 8'(`DCCF_N_GAP);
      default: line_len = 8'(`DCCF_N_GAP);
    endcase
    cnt_next = cnt_reg;
    npix_next = npix_reg;
    line_next = line_reg;
    if (clock_run) begin
      cnt_next = (cnt_reg == 4'(`DCCF_PIX_CYC - 1)) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg == 4'(`DCCF_PIX_CYC - 1)) begin
        npix_next = npix_reg + 8'h01;
        if (npix_reg == line_len - 8'h01) begin
          npix_next = 8'h00;
          case (line_reg)
            DCCF_LINE_DUMMY: line_next = DCCF_LINE_BLACK;
            DCCF_LINE_BLACK: line_next = DCCF_LINE_EFF;
            DCCF_LINE_EFF: line_next = DCCF_LINE_GAP;
            default: line_next = DCCF_LINE_DUMMY;
          endcase
        end
      end
    end
    // clock may stop in standby; strobes idle low with it
    pclk_next = clock_run && cnt_next < 4'(`DCCF_PIX_HIGH);
    ref_next = clock_run && cnt_next >= 4'(`DCCF_REF_START) && cnt_next <= 4'(`DCCF_REF_END);
    dat_next = clock_run && cnt_next >= 4'(`DCCF_DAT_START) && cnt_next <= 4'(`DCCF_DAT_END);
    icl_next = clock_run && line_next == DCCF_LINE_DUMMY;
    bcl_next = clock_run && line_next == DCCF_LINE_BLACK;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      npix_reg <= 8'h00;
      line_reg <= DCCF_LINE_DUMMY;
      pclk_reg <= 1'b0;
      ref_reg <= 1'b0;
      dat_reg <= 1'b0;
      icl_reg <= 1'b0;
      bcl_reg <= 1'b0;
      mode_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      npix_reg <= npix_next;
      line_reg <= line_next;
      pclk_reg <= pclk_next;
      ref_reg <= ref_next;
      dat_reg <= dat_next;
      icl_reg <= icl_next;
      bcl_reg <= bcl_next;
      mode_reg <= cds_mode;
    end
  end

  // ----------------------------------------
  // commands, restart guard, settle timer
  // ----------------------------------------
  logic [3:0] busy_reg, busy_next;
  logic [1:0] restart_reg, restart_next;
  logic [31:0] settle_reg, settle_next;
  logic wr_reg, rd_reg, ready_reg, stby_reg, trusted_reg, rspv_reg;
  logic wr_next, rd_next, ready_next, stby_next;
  logic [2:0] addr_reg, addr_next;
  logic [9:0] wdata_reg, wdata_next, rsp_reg;
  logic take;

  assign take = cmd_valid && ready_reg;

  always_comb begin
    busy_next = (busy_reg != 4'h0) ? busy_reg - 4'h1 : 4'h0;
    restart_next = restart_reg;
    settle_next = (settle_reg != 32'h0 && clock_run) ? settle_reg - 32'h1 : settle_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    stby_next = stby_reg;
    // count pixel clocks after a restart; a stopped clock rearms it
    if (!clock_run) begin
      restart_next = 2'h0;
    end else if (cnt_reg == 4'h0 && restart_reg != 2'(`DCCF_RESTART_PIX)) begin
      restart_next = restart_reg + 2'h1;
    end
    if (take) begin
      busy_next = 4'(`DCCF_CMD_BUSY);
      addr_next = cmd_addr;
      wdata_next = cmd_wdata;
      if (!cmd_read && cmd_addr == `DCCF_ADDR_STANDBY) begin
        stby_next = cmd_wdata[`DCCF_STANDBY_BIT];
        settle_next = 32'(SETTLE_CYC);
      end
    end
    wr_next = (take && !cmd_read) || (wr_reg && busy_reg > 4'(`DCCF_CMD_BUSY - `DCCF_CMD_HOLD));
    rd_next = (take && cmd_read) || (rd_reg && busy_reg > 4'(`DCCF_CMD_BUSY - `DCCF_CMD_HOLD));
    ready_next = busy_next == 4'h0 && restart_next == 2'(`DCCF_RESTART_PIX);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 4'h0;
      restart_reg <= 2'h0;
      settle_reg <= 32'(SETTLE_CYC);
      addr_reg <= 3'h0;
      wdata_reg <= 10'h000;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      ready_reg <= 1'b0;
      stby_reg <= 1'b0;
      trusted_reg <= 1'b0;
      rsp_reg <= 10'h000;
      rspv_reg <= 1'b0;
      pix_word <= 12'h000;
      pix_valid <= 1'b0;
      pix_odd <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      restart_reg <= restart_next;
      settle_reg <= settle_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      ready_reg <= ready_next;
      stby_reg <= stby_next;
      trusted_reg <= settle_next == 32'h0 && !stby_next;
      rsp_reg <= link.reg_rvalid ? link.reg_rdata : rsp_reg;
      rspv_reg <= link.reg_rvalid;
      pix_word <= link.out_word;
      pix_valid <= link.out_word_valid;
      pix_odd <= link.out_word_odd;
    end
  end

  assign link.pixel_clock = pclk_reg;
  assign link.reference_sample_strobe = ref_reg;
  assign link.data_sample_strobe = dat_reg;
  assign link.input_clamp_strobe = icl_reg;
  assign link.black_level_clamp_strobe = bcl_reg;
  assign link.sample_mode_select = mode_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_rd = rd_reg;
  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wdata_reg;
  assign cmd_ready = ready_reg;
  assign rsp_data = rsp_reg;
  assign rsp_valid = rspv_reg;
  assign data_trusted = trusted_reg;

endmodule : dccf_host

// ### hdl/dccf_link_if.sv
`timescale 1ns/10ps
interface dccf_link_if;
  logic pixel_clock;
  logic reference_sample_strobe;
  logic data_sample_strobe;
  logic input_clamp_strobe;
  logic black_level_clamp_strobe;
  logic sample_mode_select;
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_addr;
  logic [9:0] reg_wdata;
  logic [9:0] reg_rdata;
  logic reg_rvalid;
  logic [11:0] out_word;
  logic out_word_valid;
  logic out_word_odd;

  modport dev (
    input pixel_clock, reference_sample_strobe, data_sample_strobe, input_clamp_strobe,
    input black_level_clamp_strobe, sample_mode_select, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid, out_word, out_word_valid, out_word_odd
  );
  modport host (
    output pixel_clock, reference_sample_strobe, data_sample_strobe, input_clamp_strobe,
    output black_level_clamp_strobe, sample_mode_select, reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_rvalid, out_word, out_word_valid, out_word_odd
  );
endinterface : dccf_link_if

// ### hdl/dccf_map.svh
`ifndef DCCF_MAP_SVH
`define DCCF_MAP_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define DCCF_ADDR_CONFIG 3'h0
`define DCCF_ADDR_STANDBY 3'h1
`define DCCF_ADDR_GAIN_EVEN 3'h2
`define DCCF_ADDR_GAIN_ODD 3'h3
`define DCCF_ADDR_CLAMP_EVEN 3'h4
`define DCCF_ADDR_CLAMP_ODD 3'h5

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DCCF_CFG_ORDER_BIT 4
`define DCCF_STANDBY_BIT 0
`define DCCF_ORDER_RST 1'b0
`define DCCF_STANDBY_RST 1'b0
`define DCCF_GAIN_RST 10'h040
`define DCCF_CLAMP_RST 8'h50

// ----------------------------------------
// datapath arithmetic
// ----------------------------------------
`define DCCF_SCALE_SHIFT 8
`define DCCF_ROUND_ADD 24'h000080
`define DCCF_WORD_MAX 12'hFFF
`define DCCF_LEVEL_MAX 14'h3FFF

// ----------------------------------------
// timing
// ----------------------------------------
`define DCCF_CLK_NS 4
`define DCCF_PIX_CYC 12
`define DCCF_PIX_HIGH 6
`define DCCF_REF_START 1
`define DCCF_REF_END 2
`define DCCF_DAT_START 6
`define DCCF_DAT_END 7
`define DCCF_N_DUMMY 8
`define DCCF_N_OB 16
`define DCCF_N_EFF 64
`define DCCF_N_GAP 4
`define DCCF_CMD_HOLD 6
`define DCCF_CMD_BUSY 14
`define DCCF_RESTART_PIX 3
`define DCCF_SETTLE_MS 500
`define DCCF_SETTLE_CYC (`DCCF_SETTLE_MS * 1000000 / `DCCF_CLK_NS)

`endif

// ### hdl/dccf_pkg.sv
package dccf_pkg;

  typedef logic [13:0] dccf_sample_t;
  typedef logic [11:0] dccf_word_t;

  // gray codes along dummy -> black -> effective -> gap
  typedef enum logic [1:0] {
    DCCF_LINE_DUMMY = 2'h0,
    DCCF_LINE_BLACK = 2'h1,
    DCCF_LINE_EFF = 2'h3,
    DCCF_LINE_GAP = 2'h2
  } dccf_line_e;

endpackage : dccf_pkg

// ### testbench/dccf_link_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// link checker
// ----------------------------------------
module dccf_link_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link
  input wire logic pixel_clock,
  input wire logic black_level_clamp_strobe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [9:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic [11:0] out_word,
  input wire logic out_word_valid,
  input wire logic out_word_odd
);
  logic sb;
  logic [7:0] ce;
  logic [7:0] co;
  logic [5:0] age;
  logic [5:0] blk;
  logic [4:0] idle;
  logic [1:0] rises;
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // settings mirrored from link writes; age masks words still in flight
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sb <= 1'b0;
      ce <= 8'h50;
      co <= 8'h50;
      age <= 6'h00;
      blk <= 6'h00;
      idle <= 5'h00;
      rises <= 2'h0;
    end else begin
      if ($rose(reg_wr) && reg_addr == 3'h1) sb <= reg_wdata[0];
      if ($rose(reg_wr) && reg_addr == 3'h4) ce <= reg_wdata[7:0];
      if ($rose(reg_wr) && reg_addr == 3'h5) co <= reg_wdata[7:0];
      age <= reg_wr ? 6'h00 : age + {5'h00, age != 6'h3F};
      blk <= !black_level_clamp_strobe ? 6'h00 : blk + {5'h00, blk != 6'h3F};
      idle <= pixel_clock ? 5'h00 : idle + {4'h0, idle != 5'h1F};
      // a stopped pixel clock restarts the count of restart clocks
      if (idle == 5'h1F) rises <= 2'h0;
      else if ($rose(pixel_clock) && rises != 2'h3) rises <= rises + 2'h1;
    end
  end
  AST_WORD_PULSE: assert property (out_word_valid |=> !out_word_valid)
    else $error("word valid longer than one cycle");
  AST_WORD_HOLD: assert property (!out_word_valid |-> $stable(out_word) && $stable(out_word_odd))
    else $error("word changed without valid");
  AST_WORD_AFTER_CLK: assert property ($rose(pixel_clock) && !sb && age >= 6'd8 |-> ##3 out_word_valid)
    else $error("no word three cycles after pixel clock");
  AST_STANDBY_QUIET: assert property (sb && age >= 6'd8 |-> !out_word_valid)
    else $error("word emitted in standby");
  AST_PAIR_ALT: assert property (out_word_valid ##12 out_word_valid |-> out_word_odd != $past(out_word_odd, 12))
    else $error("even and odd words do not alternate");
  AST_BLACK_LEVEL: assert property (blk >= 6'd48 && age >= 6'd40 && out_word_valid |->
    out_word == {3'h0, (out_word_odd ? co : ce), 1'b0})
    else $error("black word differs from clamp level");
  AST_RVALID_AFTER_RD: assert property ($rose(reg_rd) |-> ##3 reg_rvalid)
    else $error("read answer late");
  AST_RVALID_PULSE: assert property (reg_rvalid |=> !reg_rvalid)
    else $error("read valid longer than one cycle");
  AST_CMD_AFTER_RESTART: assert property ($rose(reg_wr) || $rose(reg_rd) |-> rises == 2'h3)
    else $error("command before three pixel clocks");
  cover property (blk >= 6'd48 && age >= 6'd40 && out_word_valid);
  cover property (sb && age >= 6'd8);
  cover property ($rose(reg_rd));
endmodule : dccf_link_chk

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb import dccf_pkg::*; ;
  logic core_clk, rst_n, clock_run, cds_mode, cmd_valid, cmd_read, cmd_ready, rsp_valid, pix_valid, pix_odd;
  logic data_trusted, clamp_chg, sb_out, cpn, cpc, mode;
  logic [2:0] cmd_addr;
  logic [9:0] cmd_wdata, rsp_data;
  logic [3:0] h, ch;
  dccf_word_t pix_word;
  dccf_sample_t se, so;
  int n_mismatch, n_compared, xe, xo, dd, skip, busy, first_w, lv, r;
  int rm [8];
  int gl [5];
  dccf_link_if u_dccf_link_if ();
  dccf_device u_dccf_device (.core_clk, .rst_n, .link(u_dccf_link_if), .sensor_level_even(se),
    .sensor_level_odd(so), .input_clamp_charge(clamp_chg), .standby_active(sb_out));
  dccf_host #(.SETTLE_CYC(200)) u_dccf_host (.core_clk, .rst_n, .link(u_dccf_link_if), .clock_run, .cds_mode,
    .cmd_valid, .cmd_read, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_data, .rsp_valid, .pix_word, .pix_valid,
    .pix_odd, .data_trusted);
  dccf_link_chk u_chk (.core_clk, .rst_n, .pixel_clock(u_dccf_link_if.pixel_clock),
    .black_level_clamp_strobe(u_dccf_link_if.black_level_clamp_strobe), .reg_wr(u_dccf_link_if.reg_wr),
    .reg_rd(u_dccf_link_if.reg_rd), .reg_addr(u_dccf_link_if.reg_addr), .reg_wdata(u_dccf_link_if.reg_wdata),
    .reg_rvalid(u_dccf_link_if.reg_rvalid), .out_word(u_dccf_link_if.out_word),
    .out_word_valid(u_dccf_link_if.out_word_valid), .out_word_odd(u_dccf_link_if.out_word_odd));
  assign mode = u_dccf_link_if.sample_mode_select;
  assign cpn = u_dccf_link_if.input_clamp_strobe | u_dccf_link_if.black_level_clamp_strobe;
  assign cpc = u_dccf_link_if.input_clamp_strobe & (mode ? u_dccf_link_if.reference_sample_strobe :
    u_dccf_link_if.data_sample_strobe);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic cw(input dccf_word_t g, input dccf_word_t e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cw
  task automatic cr(input logic [9:0] g, input logic [9:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cr
  task automatic cb(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cb
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic cmd(input logic rd, input logic [2:0] a, input logic [9:0] d);
    int i;
    busy = 1;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) step(1);
    if (i == 200) n_mismatch++;
    if (i == 200) give_verdict();
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    step(1);
    cmd_valid = 1'b0;
    if (rd) begin
      for (i = 0; i < 50 && rsp_valid !== 1'b1; i++) step(1);
      if (i == 50) n_mismatch++;
      if (i == 50) give_verdict();
      cr(rsp_data, rm[a][9:0]);
    end else begin
      rm[a] = d;
      skip = 8;
    end
    step(12);
    busy = 0;
  endtask : cmd
  task automatic rd_all;
    for (int a = 0; a < 8; a++) cmd(1'b1, a[2:0], 10'h000);
  endtask : rd_all
  // ----------------------------------------
  // sensor drive and word model
  // ----------------------------------------
  // ref phase carries dd, data phase drops by x; clamp pixels stay flat so offset holds
  always @(posedge core_clk) begin
    #1;
    se = cpn ? 14'h2000 : u_dccf_link_if.pixel_clock ? 14'h2000 + 14'(dd) : 14'h2000 - 14'(xe);
    so = cpn ? 14'h2000 : u_dccf_link_if.pixel_clock ? 14'h2000 + 14'(dd) : 14'h2000 - 14'(xo);
  end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      h <= 4'h0;
      ch <= 4'h0;
    end else begin
      h <= {h[2:0], !rm[1][0] && cpc};
      if (busy == 0 && (h[3:1] == 3'h0 || h[3:1] == 3'h7)) cb(clamp_chg, h[2]);
      if (pix_valid === 1'b1) begin
        ch <= {ch[2:0], cpn};
        if (first_w) cb(pix_odd, rm[0][4]);
        first_w = 0;
        lv = cpn ? 0 : (pix_odd ? xo : xe) + (mode ? dd : 0);
        r = ((lv * rm[2 + pix_odd] + 128) >> 8) + 2 * rm[4 + pix_odd];
        if (skip > 0) skip--;
        else if (data_trusted === 1'b1 && ({ch, cpn} == 5'h00 || {ch, cpn} == 5'h1F))
          cw(pix_word, r > 4095 ? 12'hFFF : r[11:0]);
      end
    end
  end
  initial begin
    {rst_n, clock_run, cmd_valid, cmd_read, cmd_addr, cmd_wdata} = '0;
    {n_mismatch, n_compared, xe, xo, dd, skip, busy, first_w} = '0;
    cds_mode = 1'b1;
    rm = '{0, 0, 64, 64, 80, 80, 0, 0};
    void'($urandom(88));
    step(16);
    rst_n = 1'b1;
    clock_run = 1'b1;
    rd_all();
    xe = 100;
    xo = 37;
    step(1500);
    gl = '{0, 64, 128, 1023, 0};
    gl[4] = $urandom_range(1023);
    for (int k = 0; k < 5; k++) begin
      xe = $urandom_range(3000);
      xo = $urandom_range(3000);
      cmd(1'b0, 3'h2, gl[k][9:0]);
      cmd(1'b0, 3'h3, 10'($urandom_range(1023)));
      step(1200);
    end
    cmd(1'b0, 3'h4, 10'($urandom_range(255)));
    cmd(1'b0, 3'h5, 10'($urandom_range(255)));
    dd = 50;
    step(1200);
    cds_mode = 1'b0;
    skip = 8;
    step(1200);
    cds_mode = 1'b1;
    skip = 8;
    // order flips only while the stream is parked, so pairs never repeat a flag
    cmd(1'b0, 3'h1, 10'h001);
    cmd(1'b0, 3'h0, 10'h010);
    cb(sb_out, 1'b1);
    cb(data_trusted, 1'b0);
    rd_all();
    clock_run = 1'b0;
    step(100);
    clock_run = 1'b1;
    first_w = 1;
    cmd(1'b0, 3'h1, 10'h000);
    step(1500);
    cb(data_trusted, 1'b1);
    cmd(1'b0, 3'h1, 10'h001);
    rst_n = 1'b0;
    rm = '{0, 0, 64, 64, 80, 80, 0, 0};
    #1;
    cb(sb_out, 1'b0);
    step(3);
    rst_n = 1'b1;
    rd_all();
    give_verdict();
  end
endmodule : tb
